// ===== rtl/fan_speed_profile_mapper.sv
// Fan speed profile mapper: input PWM duty to target speed, PI loop, soft switch PWM.
// Assumes a classic Wishbone master on clk_i and a same-clock speed measurement.
// Notes on behaviour
// R1 - Max speed code maps by fixed table, 0 is 300 rpm, 0xff is 36000.
// R2 - Duty settings are 8-bit, full scale 255 equals 100 percent.
// R3 - Between min and max duty points target speed interpolates linearly.
// R4 - Above max duty: hold max speed, or drive full duty when overrange set.
// R5 - Stop threshold is five times stop code in 255ths, codes except 15.
// R6 - Stop code 0 is 0%, 1 is 1.9%, 14 is 27.4%, 15 is min duty.
// R7 - Stop code 15 uses min duty setting as the stop threshold.
// R8 - Codes 1..14 hold min speed above threshold, zero at or below it.
// R9 - Stop code 0 holds min speed below min duty, never stops.
// R10 - Min duty below computed threshold replaces the threshold.
// R11 - Restart after stop only above threshold plus 1.6% hysteresis.
// R12 - Output duty comes from a PI speed loop on the target speed.
// R13 - Duty ramps to 0% before commutation and back up after it.
// R14 - Min speed code maps by fixed table, 0 is 0, 1 is 300, 0xff 10400.
// R15 - Input PWM 25 Hz to 100 kHz accepted; output PWM fixed at 48 kHz.
// R16 - Input duty measured each period with 8-bit resolution.
// R17 - Software keeps max duty and max speed codes not below the minimums.
`timescale 1ns/1ps
`default_nettype none
module fan_speed_profile_mapper
	import fan_profile_pkg::*;
#(
	parameter int unsigned IN_TIMEOUT = IN_TIMEOUT_CYCLES,
	parameter int unsigned CTRL_TICK  = CTRL_CYCLES
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	// Motor side
	input  wire logic        pwm_cmd_i,
	input  wire logic        commutate_i,
	input  wire logic [15:0] measured_rpm_i,
	output logic             pwm_o,
	output logic             phase_o,
	output logic [15:0]      target_rpm_o,
	output logic             motor_stopped_o
);

	// ----------------------------------------------------------------
	// Speed code tables
	// ----------------------------------------------------------------
	function automatic logic [15:0] max_rpm_of(input logic [7:0] c);
		if (c < 8'h2a) return 16'(300 + 20 * int'(c));
		if (c < 8'h4a) return 16'(1160 + 40 * (int'(c) - 'h2a));
		if (c < 8'h66) return 16'(2500 + 100 * (int'(c) - 'h4a));
		return 16'(5400 + 200 * (int'(c) - 'h66));
	endfunction

	function automatic logic [15:0] min_rpm_of(input logic [7:0] c);
		if (c == 8'h00) return 16'h0000;
		if (c < 8'h54) return 16'(300 + 10 * (int'(c) - 1));
		if (c < 8'h94) return 16'(1140 + 20 * (int'(c) - 'h54));
		if (c < 8'hcc) return 16'(2450 + 50 * (int'(c) - 'h94));
		return 16'(5300 + 100 * (int'(c) - 'hcc));
	endfunction

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	cfg_type      cfg;
	logic         ack;
	logic [31:0]  rd_data;
	logic [7:0]   meas_duty;
	logic         stopped;
	logic         full_drive;
	logic [15:0]  target;
	logic [7:0]   loop_duty;
	logic [7:0]   out_duty;
	logic         phase;
	sw_state_type sw_state;

	wire        bus_req  = wb_cyc_i & wb_stb_i & ~ack;
	wire        wr_lane0 = bus_req & wb_we_i & wb_sel_i[0];
	wire [15:0] min_rpm  = min_rpm_of(cfg.min_speed); // see R14
	wire [15:0] max_rpm  = max_rpm_of(cfg.max_speed); // see R1
	wire        hit_min_speed = wb_adr_i == ADR_MIN_SPEED;
	wire        hit_max_speed = wb_adr_i == ADR_MAX_SPEED;
	wire        hit_min_duty  = wb_adr_i == ADR_MIN_DUTY;
	wire        hit_max_duty  = wb_adr_i == ADR_MAX_DUTY;
	wire        hit_stop_cfg  = wb_adr_i == ADR_STOP_CFG;
	wire        hit_status    = wb_adr_i == ADR_STATUS;
	wire        hit_speed     = wb_adr_i == ADR_SPEED;
	wire        hit_rpm_range = wb_adr_i == ADR_RPM_RANGE;
	wire [31:0] stop_word   = {27'h0, cfg.overrange, cfg.stop_code};
	wire [31:0] status_word = {8'h00, loop_duty, 5'h00, phase, full_drive, stopped, meas_duty};
	wire [31:0] speed_word  = {8'h00, out_duty, target};
	wire [31:0] read_mux =
		hit_min_speed ? {24'h0, cfg.min_speed} :
		hit_max_speed ? {24'h0, cfg.max_speed} :
		hit_min_duty  ? {24'h0, cfg.min_duty} :
		hit_max_duty  ? {24'h0, cfg.max_duty} :
		hit_stop_cfg  ? stop_word :
		hit_status    ? status_word :
		hit_speed     ? speed_word :
		hit_rpm_range ? {max_rpm, min_rpm} : 32'h0;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg.min_speed <= RST_MIN_SPEED;
			cfg.max_speed <= RST_MAX_SPEED;
			cfg.min_duty  <= RST_MIN_DUTY;
			cfg.max_duty  <= RST_MAX_DUTY;
			cfg.overrange <= RST_OVERRANGE;
			cfg.stop_code <= RST_STOP_CODE;
		end else if (wr_lane0) begin
			if (hit_min_speed)
				cfg.min_speed <= wb_dat_i[7:0];
			if (hit_max_speed)
				cfg.max_speed <= wb_dat_i[7:0];
			if (hit_min_duty)
				cfg.min_duty <= wb_dat_i[7:0]; // see R2
			if (hit_max_duty)
				cfg.max_duty <= wb_dat_i[7:0]; // see R2
			if (hit_stop_cfg) begin
				cfg.overrange <= wb_dat_i[OVR_BIT];
				cfg.stop_code <= wb_dat_i[3:0];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack     <= 1'b0;
			rd_data <= 32'h0;
		end else begin
			ack     <= bus_req;
			rd_data <= bus_req ? read_mux : 32'h0;
		end
	end

	// ----------------------------------------------------------------
	// Input duty measurement
	// ----------------------------------------------------------------
	logic [1:0]        cmd_sync;
	logic              cmd_prev;
	logic              tracking;
	logic [MEAS_W-1:0] period_cnt;
	logic [MEAS_W-1:0] high_cnt;
	logic              mdiv_done;
	logic [MEAS_W+7:0] mdiv_quo;

	wire               cmd_lvl   = cmd_sync[1];
	wire               cmd_rise  = cmd_lvl & ~cmd_prev;
	wire               mdiv_go   = cmd_rise & tracking;
	wire [MEAS_W+7:0]  high_x255 = {high_cnt, 8'h00} - {8'h00, high_cnt};
	wire               timed_out = period_cnt == MEAS_W'(IN_TIMEOUT - 1);

	seq_divider #(.NW(MEAS_W + 8), .DW(MEAS_W)) u_duty_div (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.start_i (mdiv_go),
		.num_i   (high_x255),
		.den_i   (period_cnt),
		.busy_o  (),
		.done_o  (mdiv_done),
		.quo_o   (mdiv_quo)
	);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmd_sync   <= 2'b00;
			cmd_prev   <= 1'b0;
			tracking   <= 1'b0;
			period_cnt <= '0;
			high_cnt   <= '0;
			meas_duty  <= 8'h00;
		end else begin
			cmd_sync <= {cmd_sync[0], pwm_cmd_i};
			cmd_prev <= cmd_lvl;
			if (cmd_rise) begin
				tracking   <= 1'b1; // see R15
				period_cnt <= MEAS_W'(1);
				high_cnt   <= MEAS_W'(1);
			end else if (tracking && timed_out) begin
				tracking <= 1'b0;
			end else if (tracking) begin
				period_cnt <= period_cnt + 1'b1;
				high_cnt   <= high_cnt + MEAS_W'(cmd_lvl);
			end
			if (mdiv_done)
				meas_duty <= mdiv_quo[7:0]; // see R16
			else if (!tracking)
				meas_duty <= cmd_lvl ? DUTY_FULL : 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// Stop threshold and hysteresis
	// ----------------------------------------------------------------
	wire [7:0] stop_calc = {4'h0, cfg.stop_code} * STOP_STEP; // see R5 R6
	wire       code_min  = cfg.stop_code == STOP_CODE_MIN;
	wire       code_off  = cfg.stop_code == STOP_CODE_NEVER;
	wire [7:0] stop_th   = (code_min || cfg.min_duty < stop_calc) ? cfg.min_duty : stop_calc; // see R7 R10
	wire       stop_hit  = !code_off && (code_min ? meas_duty < stop_th : meas_duty <= stop_th); // see R8 R9
	wire [8:0] restart_level = {1'b0, stop_th} + {1'b0, HYST_COUNTS};
	wire       restart_ok    = {1'b0, meas_duty} > restart_level; // see R11

	always_ff @(posedge clk_i) begin
		if (rst_i)
			stopped <= 1'b0;
		else if (code_off)
			stopped <= 1'b0; // see R9
		else if (stopped && restart_ok)
			stopped <= 1'b0;
		else if (!stopped && stop_hit)
			stopped <= 1'b1;
	end

	// ----------------------------------------------------------------
	// Profile interpolation
	// ----------------------------------------------------------------
	logic        idiv_busy;
	logic        idiv_done;
	logic [23:0] idiv_quo;
	logic [7:0]  interp_duty;

	wire        rpm_ordered = max_rpm > min_rpm;
	wire [15:0] rpm_span    = rpm_ordered ? max_rpm - min_rpm : 16'h0000;
	wire [7:0]  duty_span   = cfg.max_duty - cfg.min_duty;
	wire [7:0]  duty_over   = (meas_duty > cfg.min_duty) ? meas_duty - cfg.min_duty : 8'h00;
	wire [23:0] interp_num  = rpm_span * duty_over;
	wire        above_max   = interp_duty > cfg.max_duty;
	wire        below_min   = interp_duty <= cfg.min_duty || cfg.max_duty <= cfg.min_duty;

	seq_divider #(.NW(24), .DW(8)) u_interp_div (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.start_i (~idiv_busy),
		.num_i   (interp_num),
		.den_i   (duty_span),
		.busy_o  (idiv_busy),
		.done_o  (idiv_done),
		.quo_o   (idiv_quo)
	);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			interp_duty <= 8'h00;
			target      <= 16'h0000;
			full_drive  <= 1'b0;
		end else begin
			if (!idiv_busy)
				interp_duty <= meas_duty;
			if (idiv_done) begin
				full_drive <= !stopped && above_max && cfg.overrange; // see R4
				if (stopped)
					target <= 16'h0000; // see R8
				else if (above_max)
					target <= max_rpm; // see R4
				else if (below_min)
					target <= min_rpm; // see R9
				else
					target <= min_rpm + idiv_quo[15:0]; // see R3
			end
		end
	end

	// ----------------------------------------------------------------
	// PI speed loop
	// ----------------------------------------------------------------
	logic [31:0]        ctrl_cnt;
	logic signed [25:0] integ;

	localparam logic signed [25:0] INTEG_MAX = 26'sd255 <<< KI_SHIFT;
	wire                ctrl_tick = ctrl_cnt == CTRL_TICK - 1;
	wire signed [25:0]  err       = $signed({10'h000, target}) - $signed({10'h000, measured_rpm_i});
	wire signed [25:0]  integ_sum = integ + err;
	wire signed [25:0]  next_integ = integ_sum < 0 ? 26'sd0 :
	                                 integ_sum > INTEG_MAX ? INTEG_MAX : integ_sum;
	wire signed [25:0]  pi_sum    = (err >>> KP_SHIFT) + (next_integ >>> KI_SHIFT);
	wire [7:0]          next_loop = pi_sum < 0 ? 8'h00 :
	                                pi_sum > 26'sd255 ? DUTY_FULL : pi_sum[7:0];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_cnt  <= 32'h0;
			integ     <= 26'sd0;
			loop_duty <= 8'h00;
		end else begin
			ctrl_cnt <= ctrl_tick ? 32'h0 : ctrl_cnt + 32'h1;
			if (stopped || target == 16'h0000) begin
				integ     <= 26'sd0;
				loop_duty <= 8'h00;
			end else if (full_drive) begin
				loop_duty <= DUTY_FULL; // see R4
			end else if (ctrl_tick) begin
				integ     <= next_integ;
				loop_duty <= next_loop; // see R12
			end
		end
	end

	// ----------------------------------------------------------------
	// Soft switch and output PWM
	// ----------------------------------------------------------------
	logic [PWM_CNT_W-1:0] pwm_cnt;
	logic [ENV_W-1:0]     env;
	logic [1:0]           comm_sync;
	logic                 comm_prev;
	logic                 pwm_q;

	wire                 pwm_wrap  = pwm_cnt == PWM_CNT_W'(PWM_PERIOD_CYCLES - 1);
	wire                 comm_evt  = comm_sync[1] ^ comm_prev;
	wire [12:0]          scaled    = loop_duty * {3'h0, env};
	wire [19:0]          pwm_pos   = 20'(pwm_cnt) * 20'(DUTY_FULL);
	wire [19:0]          pwm_lim   = 20'(out_duty) * 20'(PWM_PERIOD_CYCLES);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pwm_cnt  <= '0;
			out_duty <= 8'h00;
			pwm_q    <= 1'b0;
		end else begin
			pwm_cnt <= pwm_wrap ? '0 : pwm_cnt + 1'b1; // see R15
			if (pwm_wrap)
				out_duty <= scaled[ENV_SHIFT+7:ENV_SHIFT]; // see R13
			pwm_q <= pwm_pos < pwm_lim;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			comm_sync <= 2'b00;
			comm_prev <= 1'b0;
			sw_state  <= SW_RUN;
			env       <= ENV_MAX;
			phase     <= 1'b0;
		end else begin
			comm_sync <= {comm_sync[0], commutate_i};
			comm_prev <= comm_sync[1];
			unique case (sw_state)
				SW_RUN: begin
					if (comm_evt)
						sw_state <= SW_FALL;
				end
				SW_FALL: begin
					if (pwm_wrap && env == '0) begin
						phase    <= ~phase; // see R13
						sw_state <= SW_RISE;
					end else if (pwm_wrap) begin
						env <= env - 1'b1; // see R13
					end
				end
				SW_RISE: begin
					if (comm_evt)
						sw_state <= SW_FALL;
					else if (pwm_wrap && env == ENV_MAX)
						sw_state <= SW_RUN;
					else if (pwm_wrap)
						env <= env + 1'b1; // see R13
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign wb_ack_o        = ack;
	assign wb_dat_o        = rd_data;
	assign pwm_o           = pwm_q;
	assign phase_o         = phase;
	assign target_rpm_o    = target;
	assign motor_stopped_o = stopped;

endmodule // fan_speed_profile_mapper
`default_nettype wire

// ===== rtl/fan_profile_pkg.sv
// Constants, register map and carrier types of the fan speed profile mapper.
// Assumes a single 100 MHz clock and a 32-bit classic Wishbone slave port.
package fan_profile_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ            = 100_000_000;
	localparam int unsigned PWM_OUT_HZ        = 48_000;
	localparam int unsigned PWM_PERIOD_CYCLES = CLK_HZ / PWM_OUT_HZ;
	localparam int unsigned PWM_CNT_W         = 12;
	localparam int unsigned PWM_IN_MIN_HZ     = 25;
	localparam int unsigned PWM_IN_MAX_HZ     = 100_000;
	localparam int unsigned IN_TIMEOUT_CYCLES = CLK_HZ / PWM_IN_MIN_HZ;
	localparam int unsigned MEAS_W            = 23;
	localparam int unsigned CTRL_PERIOD_US    = 1000;
	localparam int unsigned CTRL_CYCLES       = (CLK_HZ / 1_000_000) * CTRL_PERIOD_US;

	// ----------------------------------------------------------------
	// Duty and speed scaling
	// ----------------------------------------------------------------
	localparam logic [7:0]  DUTY_FULL       = 8'hff;
	localparam logic [7:0]  STOP_STEP       = 8'h05;
	localparam logic [3:0]  STOP_CODE_NEVER = 4'h0;
	localparam logic [3:0]  STOP_CODE_MIN   = 4'hf;
	localparam int unsigned HYST_PERMILLE   = 16;
	localparam logic [7:0]  HYST_COUNTS     = 8'(HYST_PERMILLE * 255 / 1000);
	localparam int unsigned ENV_W           = 5;
	localparam logic [4:0]  ENV_MAX         = 5'h10;
	localparam int unsigned ENV_SHIFT       = 4;
	localparam int unsigned KP_SHIFT        = 6;
	localparam int unsigned KI_SHIFT        = 8;

	// ----------------------------------------------------------------
	// Register map (byte addresses) and fields
	// ----------------------------------------------------------------
	localparam logic [7:0] ADR_MIN_SPEED = 8'h00;
	localparam logic [7:0] ADR_MAX_SPEED = 8'h04;
	localparam logic [7:0] ADR_MIN_DUTY  = 8'h08;
	localparam logic [7:0] ADR_MAX_DUTY  = 8'h0c;
	localparam logic [7:0] ADR_STOP_CFG  = 8'h10;
	localparam logic [7:0] ADR_STATUS    = 8'h14;
	localparam logic [7:0] ADR_SPEED     = 8'h18;
	localparam logic [7:0] ADR_RPM_RANGE = 8'h1c;
	localparam int unsigned OVR_BIT      = 4;

	localparam logic [7:0] RST_MIN_SPEED = 8'h00;
	localparam logic [7:0] RST_MAX_SPEED = 8'hff;
	localparam logic [7:0] RST_MIN_DUTY  = 8'h00;
	localparam logic [7:0] RST_MAX_DUTY  = 8'hff;
	localparam logic [3:0] RST_STOP_CODE = 4'h0;
	localparam logic       RST_OVERRANGE = 1'b0;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] min_speed;
		logic [7:0] max_speed;
		logic [7:0] min_duty;
		logic [7:0] max_duty;
		logic       overrange;
		logic [3:0] stop_code;
	} cfg_type;

	typedef enum {SW_RUN, SW_FALL, SW_RISE} sw_state_type;

endpackage

// ===== rtl/seq_divider.sv
// Sequential restoring divider, one quotient bit per clock.
// Assumes start is ignored while busy; divide by zero gives all ones.
`timescale 1ns/1ps
`default_nettype none
module seq_divider #(
	parameter int unsigned NW = 24,
	parameter int unsigned DW = 8
) (
	// Clock and reset
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	// Operands
	input  wire logic          start_i,
	input  wire logic [NW-1:0] num_i,
	input  wire logic [DW-1:0] den_i,
	// Result
	output logic               busy_o,
	output logic               done_o,
	output logic [NW-1:0]      quo_o
);
	localparam int unsigned CW = $clog2(NW + 1);

	logic [NW-1:0] quo;
	logic [DW-1:0] rem;
	logic [DW-1:0] den;
	logic [CW-1:0] cnt;
	logic          busy;
	logic          done;

	wire [DW:0] trial = {rem, quo[NW-1]};
	wire        take  = trial >= {1'b0, den};
	wire [DW:0] diff  = trial - {1'b0, den};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			quo  <= '0;
			rem  <= '0;
			den  <= '0;
			cnt  <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (!busy && start_i) begin
				quo  <= num_i;
				rem  <= '0;
				den  <= den_i;
				cnt  <= CW'(NW);
				busy <= 1'b1;
			end else if (busy) begin
				rem <= take ? diff[DW-1:0] : trial[DW-1:0];
				quo <= {quo[NW-2:0], take};
				cnt <= cnt - 1'b1;
				if (cnt == CW'(1)) begin
					busy <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end

	assign busy_o = busy;
	assign done_o = done;
	assign quo_o  = quo;
endmodule // seq_divider
`default_nettype wire

// ===== testbench/fan_profile_mapper_asserts.sv
// Checker for the fan speed profile mapper, bound to its top module.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module fan_profile_mapper_asserts
	import fan_profile_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Bus
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic [31:0] wb_dat_o,
	input  wire logic        wb_ack_o,
	// Motor side
	input  wire logic        pwm_o,
	input  wire logic        phase_o,
	input  wire logic [15:0] target_rpm_o,
	input  wire logic        motor_stopped_o
);
	logic [6:0]  stop_cnt;
	logic [15:0] gap;
	logic        seen;
	logic        pwm_q;

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// ----------------------------------------------------------------
	// Stop age and output pulse spacing
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stop_cnt <= '0;
			gap      <= '0;
			seen     <= 1'b0;
			pwm_q    <= 1'b0;
		end else begin
			pwm_q    <= pwm_o;
			stop_cnt <= !motor_stopped_o ? 7'h00 : stop_cnt + 7'(stop_cnt != 7'h7f);
			gap      <= (pwm_o && !pwm_q) ? 16'h0001 : gap + 16'(gap != 16'hffff);
			if (pwm_o && !pwm_q)
				seen <= 1'b1;
			else if (gap == 16'hffff)
				seen <= 1'b0;
		end
	end

	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered next cycle");
	a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	a_stop_target: assert property (stop_cnt >= 7'd32 |-> target_rpm_o == 16'h0)
		else $error("target not zero while stopped");
	a_phase_at_zero: assert property ($changed(phase_o) |-> !$past(pwm_o, 1) && !$past(pwm_o, 8))
		else $error("phase changed with output active");
	a_reset_quiet: assert property ($past(rst_i) |-> !pwm_o && !phase_o && target_rpm_o == 16'h0)
		else $error("outputs active after reset");
	a_pwm_period: assert property (pwm_o && !pwm_q && seen |-> gap % 16'(PWM_PERIOD_CYCLES) == 0)
		else $error("output pulse off the fixed period");

	cover property (wb_ack_o);
	cover property ($rose(motor_stopped_o));
	cover property ($changed(phase_o));
endmodule // fan_profile_mapper_asserts

bind fan_speed_profile_mapper fan_profile_mapper_asserts u_chk (.clk_i, .rst_i, .wb_cyc_i,
	.wb_stb_i, .wb_dat_o, .wb_ack_o, .pwm_o, .phase_o, .target_rpm_o, .motor_stopped_o);
`default_nettype wire

// ===== testbench/pwm_cmd_model.sv
// System controller model driving the speed command PWM pin.
// Assumes the bench gives period and high time in clocks of clk_i.
`timescale 1ns/1ps
`default_nettype none
module pwm_cmd_model (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Waveform settings
	input  wire logic [15:0] period_i,
	input  wire logic [15:0] high_i,
	// Command pin
	output logic             pwm_cmd_o
);
	logic [15:0] cnt;

	// Period of period_i clocks, high for the first high_i of them
	always_ff @(posedge clk_i) begin
		if (rst_i || cnt + 16'h0001 >= period_i)
			cnt <= 16'h0;
		else
			cnt <= cnt + 16'h0001;
		pwm_cmd_o <= !rst_i && (cnt < high_i);
	end
endmodule // pwm_cmd_model
`default_nettype wire

// ===== testbench/tb_top.sv
// Bench: register access, duty to speed mapping, stop hysteresis, commutation.
// Assumes the bound checker and the command model beside the design.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import fan_profile_pkg::*;

	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [3:0]  sel = 4'h0;
	logic [31:0] rdat;
	logic        ack;
	logic        cmd;
	logic        comm = 1'b0;
	logic [15:0] meas = 16'h0;
	logic        pwm;
	logic        phase;
	logic [15:0] target;
	logic        stopped;
	logic [15:0] high = 16'h0;
	logic [31:0] q;
	int          err_count = 0;
	int          checks = 0;
	logic [7:0]  radr [6] = '{ADR_MIN_SPEED, ADR_MAX_SPEED, ADR_MIN_DUTY, ADR_MAX_DUTY,
		ADR_STOP_CFG, 8'h20};
	logic [31:0] rval [6] = '{32'(RST_MIN_SPEED), 32'(RST_MAX_SPEED), 32'(RST_MIN_DUTY),
		32'(RST_MAX_DUTY), 32'(RST_STOP_CODE), 32'h0};
	logic [7:0]  code [3] = '{8'h00, 8'h01, 8'hff};
	logic [31:0] rng [3] = '{{16'd300, 16'd0}, {16'd320, 16'd300}, {16'd36000, 16'd10400}};

	always #5 clk = ~clk;

	fan_speed_profile_mapper #(.IN_TIMEOUT(4000), .CTRL_TICK(100)) u_dut (
		.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
		.pwm_cmd_i(cmd), .commutate_i(comm), .measured_rpm_i(meas), .pwm_o(pwm),
		.phase_o(phase), .target_rpm_o(target), .motor_stopped_o(stopped));

	pwm_cmd_model u_host (.clk_i(clk), .rst_i(rst), .period_i(16'd1020), .high_i(high),
		.pwm_cmd_o(cmd));

	// ----------------------------------------------------------------
	// Access and compare tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= s;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (ack !== 1'b1)
			check({31'h0, ack}, 32'h1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d, 4'hf);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0, 4'hf);
		check(q, exp);
	endtask

	// Duty d in 255ths: high time 4*d of a 1020-clock period
	task automatic run(input logic [7:0] d, input logic [15:0] rpm, input logic stop);
		high <= 16'({d, 2'b00});
		repeat (3500) @(posedge clk);
		check({15'h0, stopped, target}, {15'h0, stop, rpm});
	endtask

	task automatic results;
		if (err_count == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		foreach (radr[i])
			rd(radr[i], rval[i]);
		xfer(1'b1, ADR_MIN_DUTY, 32'h55, 4'h0);
		rd(ADR_MIN_DUTY, 32'h0);
		wr(ADR_RPM_RANGE, 32'hffffffff);
		foreach (code[i]) begin
			wr(ADR_MIN_SPEED, 32'(code[i]));
			wr(ADR_MAX_SPEED, 32'(code[i]));
			rd(ADR_RPM_RANGE, rng[i]);
		end
		wr(ADR_MIN_SPEED, 32'h01);
		wr(ADR_MIN_DUTY, 32'h40);
		wr(ADR_MAX_DUTY, 32'h80);
		run(8'h60, 16'd18150, 1'b0);
		run(8'h40, 16'd300, 1'b0);
		run(8'h90, 16'd36000, 1'b0);
		wr(ADR_STOP_CFG, 32'h10);
		repeat (200) @(posedge clk);
		rd(ADR_STATUS, 32'h00ff0290);
		check({23'h0, q[23:16], q[9]}, {23'h0, 8'hff, 1'b1});
		wr(ADR_STOP_CFG, 32'h04);
		run(8'h20, 16'd300, 1'b0);
		run(8'h14, 16'd0, 1'b1);
		run(8'h18, 16'd0, 1'b1);
		run(8'h19, 16'd300, 1'b0);
		wr(ADR_STOP_CFG, 32'h00);
		run(8'h01, 16'd300, 1'b0);
		wr(ADR_STOP_CFG, 32'h0f);
		run(8'h3f, 16'd0, 1'b1);
		run(8'h46, 16'd3646, 1'b0);
		wr(ADR_STOP_CFG, 32'h0e);
		run(8'h42, 16'd1415, 1'b0);
		rd(ADR_STATUS, 32'h00ff0042);
		check(32'(q[23:16] != 8'h0), 32'h1);
		comm <= ~comm;
		for (int n = 0; n < 45000 && phase !== 1'b1; n++)
			@(posedge clk);
		check({31'h0, phase}, 32'h1);
		results();
	end

	initial begin
		repeat (95000) @(posedge clk);
		err_count++;
		results();
	end
endmodule // tb_top
`default_nettype wire
